// ===== mcdp_regs.svh
// Constants for the meter calibration datapath
`ifndef MCDP_REGS_SVH
`define MCDP_REGS_SVH
`define MCDP_PHASE_ZERO      8'sh0D
`define MCDP_CURRENT_RMS_RESULT_OS_SCALE   32'h00008000
`define MCDP_GAIN_SHIFT      12
`define MCDP_ENERGY_DIV      4
`define MCDP_ADC_DIV         8
`define MCDP_WAVE_BASE_LOG2  7
`define MCDP_PHASE_STEP      4
`define MCDP_LPF_SHIFT       6
`define MCDP_ZERO_CROSS_MODE 1'b1
`endif

// ===== mcdp_pkg.sv
// Types shared by the meter calibration datapath
`default_nettype none
package mcdp_pkg;
	typedef logic signed [15:0] mcdp_sample_t;
	typedef logic [1:0]         mcdp_wave_sel_t;
	typedef enum logic [1:0] {
		MCDP_ROOT_IDLE = 2'b00,
		MCDP_ROOT_RUN  = 2'b01,
		MCDP_ROOT_DONE = 2'b10
	} mcdp_root_state_t;
endpackage
`default_nettype wire

// ===== mcdp_sqrt.sv
// Sequential integer square root, one result bit per cycle
`timescale 1ns/1ps
`default_nettype none
module mcdp_sqrt (
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        start_in,
	input  wire logic [31:0] radicand_in,
	output logic             done_out,
	output logic [15:0]      root_out
);
	import mcdp_pkg::*;
	typedef struct packed {
		mcdp_root_state_t st;
		logic [31:0]      rem;
		logic [15:0]      root;
		logic [4:0]       bitn;
		logic             done;
	} mcdp_sqrt_state_t;
	mcdp_sqrt_state_t s_q, s_d;
	logic [15:0] trial;
	// Bit-by-bit restoring root
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		trial = s_q.root | (16'h0001 << s_q.bitn[3:0]);
		unique case (s_q.st)
			MCDP_ROOT_IDLE: begin
				if (start_in) begin
					s_d.rem  = radicand_in;
					s_d.root = 16'h0000;
					s_d.bitn = 5'h0F;
					s_d.st   = MCDP_ROOT_RUN;
				end
			end
			MCDP_ROOT_RUN: begin
				if ({16'h0000, trial} * {16'h0000, trial} <= s_q.rem)
					s_d.root = trial;
				if (s_q.bitn == 5'h00)
					s_d.st = MCDP_ROOT_DONE;
				else
					s_d.bitn = s_q.bitn - 5'h01;
			end
			MCDP_ROOT_DONE: begin
				s_d.done = 1'b1;
				s_d.st   = MCDP_ROOT_IDLE;
			end
			default: s_d.st = MCDP_ROOT_IDLE;
		endcase
	end
	// State register
	always_ff @(posedge clk_in) begin
		if (!reset_n_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign done_out = s_q.done;
	assign root_out = s_q.root;
endmodule
`default_nettype wire

// ===== mcdp_top.sv
// Meter calibration datapath: rms, apparent energy, rates, phase trim
`timescale 1ns/1ps
`default_nettype none
`include "mcdp_regs.svh"
module mcdp_top #(
	parameter int DELAY_DEPTH = 64
) (
	input  wire logic                  CLK_IN,
	input  wire logic                  RESET_N_IN,
	input  wire mcdp_pkg::mcdp_sample_t VOLT_SAMPLE_IN,
	input  wire mcdp_pkg::mcdp_sample_t CURR_SAMPLE_IN,
	input  wire logic signed [7:0]     PHASE_TRIM_IN,
	input  wire logic signed [11:0]    VOLTAGE_RMS_OFFSET_IN,
	input  wire logic signed [11:0]    CURRENT_RMS_OFFSET_IN,
	input  wire logic signed [11:0]    APPARENT_GAIN_TRIM_IN,
	input  wire logic [7:0]            APPARENT_ENERGY_DIVIDER_IN,
	input  wire mcdp_pkg::mcdp_wave_sel_t WAVEFORM_RATE_SELECT_IN,
	input  wire logic                  ZERO_CROSS_IRQ_EN_IN,
	input  wire logic                  LINE_CYCLE_END_IN,
	output logic [15:0]                VOLTAGE_RMS_RESULT_OUT,
	output logic [15:0]                CURRENT_RMS_RESULT_OUT,
	output logic [31:0]                APPARENT_ENERGY_ACC_OUT,
	output logic [31:0]                LINE_ACTIVE_ENERGY_OUT,
	output logic [31:0]                LINE_APPARENT_ENERGY_OUT,
	output logic                       LINE_CYCLE_IRQ_OUT,
	output logic                       WAVE_SAMPLE_STROBE_OUT,
	output mcdp_pkg::mcdp_sample_t     WAVE_SAMPLE_OUT,
	output logic                       IRQ_N_OUT
);
	import mcdp_pkg::*;

	// Block state in one record, except the voltage delay line
	typedef struct packed {
		logic [9:0]  div_cnt;      // Free-running divider off the clock
		logic [31:0] v_ms;         // Voltage mean-square filter
		logic [31:0] i_ms;         // Current mean-square filter
		logic [15:0] voltage_rms_result;         // Saturated voltage rms
		logic [15:0] current_rms_result;         // Current rms
		logic        root_sel;     // Which channel the root unit serves
		logic        root_busy;    // Root unit in use
		logic [31:0] act_acc;      // Running active energy
		logic [31:0] app_raw;      // Undivided apparent energy
		logic [31:0] app_acc;      // Divided apparent energy
		logic [31:0] app_tot;      // Undivided running apparent energy
		logic [31:0] line_act;     // Latched line-cycle active energy
		logic [31:0] line_app;     // Latched line-cycle apparent energy
		logic        line_irq;     // Line-cycle done pulse
		logic        wave_stb;     // Waveform sample strobe
		mcdp_sample_t wave;        // Waveform sample
		logic        v_sign;       // Last voltage sign for crossings
		logic        irq_n;        // Interrupt pin level
		logic [5:0]  wr_ptr;       // Delay line write pointer
	} mcdp_state_t;

	mcdp_state_t s_q, s_d;
	mcdp_sample_t dly_mem [DELAY_DEPTH];  // Voltage delay line
	mcdp_sample_t v_shift;                // Trim-shifted voltage sample
	logic signed [31:0] v_sq, i_sq;
	logic signed [31:0] p_inst;
	logic [31:0] root_arg;
	logic        root_start;
	logic        root_done;
	logic [15:0] root_val;
	logic signed [8:0] trim_rel;
	logic [5:0]  rd_ptr;
	logic        adc_tick, nrg_tick, wave_tick;
	logic signed [17:0] voltage_rms_result_corr;
	logic signed [33:0] i_corr;
	logic signed [45:0] app_gain;
	logic signed [45:0] app_tot_gain;     // Trimmed running apparent energy
	logic signed [13:0] gain_q12;         // Unity plus signed trim, Q12
	logic [31:0] app_pwr;                 // Apparent power per energy tick
	logic [7:0]  app_div;                 // Divider, zero acting as one

	// Divider tick selection by rate code
	function automatic logic wave_due(input logic [9:0] c,
		input mcdp_wave_sel_t sel);
		logic [9:0] mask;
		mask = 10'h3FF >> (3 - sel);
		return (c & mask) == 10'h000;
	endfunction

	mcdp_sqrt u_root (
		.clk_in      (CLK_IN),
		.reset_n_in  (RESET_N_IN),
		.start_in    (root_start),
		.radicand_in (root_arg),
		.done_out    (root_done),
		.root_out    (root_val)
	);

	// Voltage delay line, tapped by phase trim; cleared in reset so an
	// unwritten slot never feeds an unknown into the mean-square filter
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			for (int k = 0; k < DELAY_DEPTH; k++)
				dly_mem[k] <= '0;
		end else if (adc_tick)
			dly_mem[s_q.wr_ptr] <= VOLT_SAMPLE_IN;
	end

	// Combinational datapath and next state
	always_comb begin
		s_d = s_q;
		s_d.div_cnt = s_q.div_cnt + 10'h001;
		adc_tick = s_q.div_cnt[2:0] == 3'h0;
		nrg_tick = s_q.div_cnt[1:0] == 2'h0;
		wave_tick = wave_due(s_q.div_cnt, WAVEFORM_RATE_SELECT_IN);
		// Offset from centre sets delay; positive delays
		trim_rel = 9'(PHASE_TRIM_IN) - 9'(`MCDP_PHASE_ZERO);
		// Step of four clocks is half an eight-clock sample slot
		rd_ptr = s_q.wr_ptr - 6'h01
			- 6'(trim_rel >>> 1) - 6'(DELAY_DEPTH / 2);
		v_shift = dly_mem[rd_ptr];
		v_sq = v_shift * v_shift;
		i_sq = CURR_SAMPLE_IN * CURR_SAMPLE_IN;
		p_inst = v_shift * CURR_SAMPLE_IN;
		if (adc_tick) begin
			if (s_q.wr_ptr == 6'(DELAY_DEPTH - 1))
				s_d.wr_ptr = 6'h00;
			else
				s_d.wr_ptr = s_q.wr_ptr + 6'h01;
			// First order low-pass gives the mean square
			s_d.v_ms = s_q.v_ms - (s_q.v_ms >> `MCDP_LPF_SHIFT)
				+ (32'(v_sq) >> `MCDP_LPF_SHIFT);
			s_d.i_ms = s_q.i_ms - (s_q.i_ms >> `MCDP_LPF_SHIFT)
				+ (32'(i_sq) >> `MCDP_LPF_SHIFT);
			// Zero crossing detect on voltage sign
			s_d.v_sign = v_shift[15];
			s_d.irq_n = !(ZERO_CROSS_IRQ_EN_IN
				&& (v_shift[15] != s_q.v_sign));
		end
		// Current offset enters before root, scaled by 32768
		i_corr = 34'(s_q.i_ms)
			+ 34'(CURRENT_RMS_OFFSET_IN) * 34'(`MCDP_CURRENT_RMS_RESULT_OS_SCALE);
		if (i_corr < 0)
			i_corr = 34'sh0;
		else if (i_corr > 34'sh0FFFFFFFF)
			i_corr = 34'sh0FFFFFFFF;
		root_arg = s_q.root_sel ? i_corr[31:0] : s_q.v_ms;
		root_start = !s_q.root_busy;
		if (root_start)
			s_d.root_busy = 1'b1;
		// Voltage offset enters after root, saturated
		voltage_rms_result_corr = 18'(root_val) + 18'(VOLTAGE_RMS_OFFSET_IN);
		if (root_done) begin
			s_d.root_busy = 1'b0;
			s_d.root_sel = !s_q.root_sel;
			if (s_q.root_sel)
				s_d.current_rms_result = root_val;
			else if (voltage_rms_result_corr < 0)
				s_d.voltage_rms_result = 16'h0000;
			else if (voltage_rms_result_corr > 18'sh0FFFF)
				s_d.voltage_rms_result = 16'hFFFF;
			else
				s_d.voltage_rms_result = voltage_rms_result_corr[15:0];
		end
		// Apparent power is the rms product, upper half kept
		app_pwr = 32'((32'(s_q.voltage_rms_result) * 32'(s_q.current_rms_result)) >> 16);
		// A zero divider would divide by nothing, so it acts as one
		app_div = (APPARENT_ENERGY_DIVIDER_IN == 8'h00) ? 8'h01
			: APPARENT_ENERGY_DIVIDER_IN;
		// Gain trim is a signed fraction around unity
		gain_q12 = 14'sd4096 + 14'(APPARENT_GAIN_TRIM_IN);
		app_gain = 46'(s_q.app_raw) * 46'(gain_q12)
			>>> `MCDP_GAIN_SHIFT;
		app_tot_gain = 46'(s_q.app_tot) * 46'(gain_q12)
			>>> `MCDP_GAIN_SHIFT;
		// Running apparent energy: gain trimmed, then divided
		s_d.app_acc = 32'(app_tot_gain / 46'(app_div));
		// Energy accumulation on the four-clock tick
		if (nrg_tick) begin
			s_d.act_acc = s_q.act_acc + 32'(p_inst >>> 16);
			s_d.app_raw = s_q.app_raw + app_pwr;
			s_d.app_tot = s_q.app_tot + app_pwr;
		end
		// Both line energies latched in one edge, then cleared
		s_d.line_irq = LINE_CYCLE_END_IN;
		if (LINE_CYCLE_END_IN) begin
			s_d.line_act = s_q.act_acc;
			s_d.line_app = 32'(app_gain / 46'(app_div));
			s_d.act_acc = 32'h00000000;
			s_d.app_raw = 32'h00000000;
		end
		s_d.wave_stb = wave_tick;
		if (wave_tick)
			s_d.wave = v_shift;
	end

	// State register
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			s_q <= '0;
			s_q.irq_n <= 1'b1;
		end else
			s_q <= s_d;
	end

	assign VOLTAGE_RMS_RESULT_OUT   = s_q.voltage_rms_result;
	assign CURRENT_RMS_RESULT_OUT   = s_q.current_rms_result;
	assign APPARENT_ENERGY_ACC_OUT  = s_q.app_acc;
	assign LINE_ACTIVE_ENERGY_OUT   = s_q.line_act;
	assign LINE_APPARENT_ENERGY_OUT = s_q.line_app;
	assign LINE_CYCLE_IRQ_OUT       = s_q.line_irq;
	assign WAVE_SAMPLE_STROBE_OUT   = s_q.wave_stb;
	assign WAVE_SAMPLE_OUT          = s_q.wave;
	assign IRQ_N_OUT                = s_q.irq_n;
	// Serial link lives elsewhere on its own clock; none here
endmodule
`default_nettype wire

// ===== mcdp_assertions.sv
// Port-level assertion checker for the calibration datapath
`timescale 1ns/1ps
`default_nettype none
module mcdp_assertions (
	input wire logic                    CLK_IN,
	input wire logic                    RESET_N_IN,
	input wire logic                    LINE_CYCLE_END_IN,
	input wire logic                    ZERO_CROSS_IRQ_EN_IN,
	input wire logic                    LINE_CYCLE_IRQ_OUT,
	input wire logic [31:0]             LINE_ACTIVE_ENERGY_OUT,
	input wire logic [31:0]             LINE_APPARENT_ENERGY_OUT,
	input wire logic                    WAVE_SAMPLE_STROBE_OUT,
	input wire mcdp_pkg::mcdp_sample_t  WAVE_SAMPLE_OUT,
	input wire logic                    IRQ_N_OUT
);
	import mcdp_pkg::*;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	chk_irq_after_end: assert property (
		LINE_CYCLE_END_IN |=> LINE_CYCLE_IRQ_OUT)
		else $error("line irq missing");
	chk_irq_no_spur: assert property (
		!LINE_CYCLE_END_IN |=> !LINE_CYCLE_IRQ_OUT)
		else $error("line irq without line end");
	chk_line_hold: assert property (
		!LINE_CYCLE_END_IN |=> $stable(LINE_ACTIVE_ENERGY_OUT)
		&& $stable(LINE_APPARENT_ENERGY_OUT))
		else $error("line energy moved between ends");
	chk_wave_gap: assert property (
		WAVE_SAMPLE_STROBE_OUT |=> !WAVE_SAMPLE_STROBE_OUT [*8])
		else $error("wave strobes too close");
	chk_wave_data: assert property (
		$changed(WAVE_SAMPLE_OUT) |-> WAVE_SAMPLE_STROBE_OUT)
		else $error("wave sample moved without strobe");
	chk_zc_masked: assert property (
		!ZERO_CROSS_IRQ_EN_IN && IRQ_N_OUT |=> IRQ_N_OUT)
		else $error("pin asserted while masked");
	chk_zc_cause: assert property (
		$fell(IRQ_N_OUT) |-> $past(ZERO_CROSS_IRQ_EN_IN))
		else $error("pin fell with enable low");
	chk_zc_width: assert property (
		$fell(IRQ_N_OUT) |-> !IRQ_N_OUT [*8])
		else $error("pin low pulse too short");
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the calibration datapath
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mcdp_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, ze = 1'b0, le = 1'b0;
	mcdp_sample_t vs = 16'h0000, cs = 16'h0000, wso;
	mcdp_wave_sel_t ws = 2'b00; // Waveform rate select
	logic signed [7:0] pt = 8'sh0D; // Phase trim
	logic signed [11:0] vo = 12'sh000, co = 12'sh000, gt = 12'sh000;
	logic [7:0] dv = 8'h00; // Apparent divider
	logic [15:0] vr, cr, vr_o, cr_o; // Rms results, seen and raw
	logic [31:0] ae, la, lva, ae_o, la_o, lva_o; // Energies
	logic li, wst, irq_n, li_o, wst_o, irq_o; // Line irq, strobe, pin
	mcdp_sample_t wso_o; // Raw waveform sample
	int err_total = 0, tests_run = 0, cyc = 0, n, b, p_app;
	logic [31:0] a1; // Apparent energy before a window
	logic signed [11:0] vt[3] = '{12'sh123, 12'sh800, 12'sh7FF};
	logic signed [11:0] ct[3] = '{12'sh008, 12'sh002, 12'shFF0};
	logic signed [7:0] tt[3] = '{8'sh0D, 8'sh15, 8'sh05};
	int dt[3] = '{0, 32, -32}; // Expected latency shift per trim
	always #10 clk = ~clk;
	mcdp_top uut (.CLK_IN(clk), .RESET_N_IN(rst_n), .VOLT_SAMPLE_IN(vs),
		.CURR_SAMPLE_IN(cs), .PHASE_TRIM_IN(pt),
		.VOLTAGE_RMS_OFFSET_IN(vo), .CURRENT_RMS_OFFSET_IN(co),
		.APPARENT_GAIN_TRIM_IN(gt), .APPARENT_ENERGY_DIVIDER_IN(dv),
		.WAVEFORM_RATE_SELECT_IN(ws), .ZERO_CROSS_IRQ_EN_IN(ze),
		.LINE_CYCLE_END_IN(le), .VOLTAGE_RMS_RESULT_OUT(vr_o),
		.CURRENT_RMS_RESULT_OUT(cr_o), .APPARENT_ENERGY_ACC_OUT(ae_o),
		.LINE_ACTIVE_ENERGY_OUT(la_o), .LINE_APPARENT_ENERGY_OUT(lva_o),
		.LINE_CYCLE_IRQ_OUT(li_o), .WAVE_SAMPLE_STROBE_OUT(wst_o),
		.WAVE_SAMPLE_OUT(wso_o), .IRQ_N_OUT(irq_o));
	// Outputs are looked at half a period after the edge that launches them
	always @(negedge clk) begin
		vr <= vr_o;
		cr <= cr_o;
		ae <= ae_o;
		la <= la_o;
		lva <= lva_o;
		li <= li_o;
		wst <= wst_o;
		wso <= wso_o;
		irq_n <= irq_o;
	end
	// Expected line apparent energy from ticks, power, trim and divider
	function automatic logic [31:0] app_exp(input int t, input int p,
		input logic signed [11:0] g, input logic [7:0] d);
		longint e;
		e = (longint'(t) * p * (4096 + g)) >>> 12;
		return 32'(e / (d == 8'h00 ? 1 : d));
	endfunction
	// Integer square root for the expected current result
	function automatic logic [15:0] isqrt(input logic [31:0] x);
		logic [15:0] r = 16'h0000;
		logic [15:0] t;
		for (int i = 15; i >= 0; i--) begin
			t = r | (16'h0001 << i);
			if (32'(t) * 32'(t) <= x) r = t;
		end
		return r;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	// End a line cycle and expect the irq one edge later
	task automatic pulse;
		le <= 1'b1;
		tick(1);
		le <= 1'b0;
		tick(1);
		chk(32'(li), 32'h1);
	endtask
	// Wait for the next waveform strobe, counting cycles
	task automatic strobe;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (wst !== 1'b1 && n < 3000);
	endtask
	task automatic close_out;
		$display("errors %0d, checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		n = $urandom(32'h92521977);
		tick(2);
		rst_n <= 1'b1;
		chk(32'(irq_n), 32'h1);
		chk(la, 32'h0);
		// Zero input: results show the offsets alone
		for (int i = 0; i < 3; i++) begin
			vo <= vt[i];
			co <= ct[i];
			tick(200);
			chk(32'(vr), vt[i] < 0 ? 32'h0 : 32'(vt[i]));
			chk(32'(cr), ct[i] < 0 ? 32'h0 : 32'(isqrt(32'(ct[i]) << 15)));
		end
		// Back-to-back line ends, then an idle cycle stays empty
		le <= 1'b1;
		tick(1);
		pulse();
		tick(300);
		pulse();
		chk(la | lva, 32'h0);
		// Offsets alone give a steady apparent power
		co <= 12'sh7FF;
		dv <= 8'h01;
		p_app = (2047 * int'(isqrt(32'h7FF << 15))) >>> 16;
		tick(200);
		a1 = ae;
		tick(400);
		chk(ae - a1, 32'(100 * p_app));
		// Line ends 401 edges apart enclose exactly 100 energy ticks
		dv <= 8'($urandom % 4);
		gt <= 12'($urandom);
		pulse();
		tick(399);
		pulse();
		chk(lva, app_exp(100, p_app, gt, dv));
		chk(la, 32'h0);
		vs <= 16'(16'h1000 + $urandom % 8192);
		cs <= 16'(16'h1000 + $urandom % 8192);
		dv <= 8'($urandom % 4);
		gt <= 12'($urandom);
		tick(3000);
		pulse();
		chk(32'(la > 32'h0 && lva > 32'h0), 32'h1);
		for (int s = 0; s < 4; s++) begin
			ws <= 2'(s);
			repeat (3) strobe();
			chk(n, 32'h80 << s);
		end
		// Crossing latency moves with the phase trim
		ze <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			pt <= tt[i];
			vs <= 16'hC000;
			tick(600);
			while (cyc % 8 != 0) tick(1);
			vs <= 16'(16'h0100 + $urandom % 16384);
			n = 0;
			while (irq_n !== 1'b0 && n < 2000) begin
				tick(1);
				n++;
			end
			if (i == 0) b = n;
			chk(32'(n < 2000), 32'h1);
			chk(n - b, dt[i]);
		end
		ze <= 1'b0;
		ws <= 2'b00;
		vs <= 16'hC000;
		tick(600);
		chk(32'(irq_n), 32'h1);
		chk({16'h0000, wso}, 32'h0000C000);
		close_out();
	end
endmodule
bind mcdp_top mcdp_assertions chk_i (.*);
`default_nettype wire
